/* File: rtl/wtp_pkg.sv */
// Constants, field helpers and types for the window threshold and peak register slice
package wtp_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int NUM_CH = 8;
    localparam int CH_W = 3;
    localparam int CODE_W = 12;
    localparam int IDX_W = 8;
    localparam int IDX_LSB = 2;
    localparam int HYST_SHIFT = 3;

    // ****************************************************************
    // Register indices, byte address is four times the index
    // ****************************************************************
    localparam logic [7:0] IDX_MON_BASE = 8'h20;
    localparam logic [7:0] IDX_FLOOR_UPPER_CH6 = 8'h3B;
    localparam logic [7:0] IDX_HYST_CEIL_LOWER_CH7 = 8'h3C;
    localparam logic [7:0] IDX_CEIL_UPPER_CH7 = 8'h3D;
    localparam logic [7:0] IDX_FLOOR_LOWER_DEB_CH7 = 8'h3E;
    localparam logic [7:0] IDX_FLOOR_UPPER_CH7 = 8'h3F;
    localparam logic [7:0] IDX_PEAK_BASE = 8'h60;
    localparam logic [7:0] IDX_PEAK_LOWER_CH0 = 8'h60;
    localparam logic [7:0] IDX_PEAK_UPPER_CH0 = 8'h61;
    localparam logic [7:0] IDX_PEAK_LOWER_CH1 = 8'h62;
    localparam logic [7:0] IDX_PEAK_UPPER_CH1 = 8'h63;
    localparam logic [7:0] IDX_PEAK_LOWER_CH2 = 8'h64;
    localparam logic [7:0] IDX_EVENT_STATUS = 8'h70;
    localparam logic [7:0] IDX_EVENT_MASK = 8'h71;
    localparam logic [7:0] MON_SPAN = 8'h20;
    localparam logic [7:0] PEAK_SPAN = 8'h10;

    // Position of a register inside a channel's group of four
    localparam logic [1:0] FLD_HYST = 2'h0;
    localparam logic [1:0] FLD_CEIL = 2'h1;
    localparam logic [1:0] FLD_DEB = 2'h2;
    localparam logic [1:0] FLD_FLOOR = 2'h3;

    // ****************************************************************
    // Reset values and bus answers
    // ****************************************************************
    localparam logic [7:0] RST_HYST = 8'hF0;
    localparam logic [7:0] RST_CEIL = 8'hFF;
    localparam logic [7:0] RST_DEB = 8'h00;
    localparam logic [7:0] RST_FLOOR = 8'h00;
    localparam logic [11:0] RST_PEAK = 12'h000;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic mon;
        logic pk;
        logic st;
        logic mk;
        logic [CH_W-1:0] ch;
        logic [1:0] fld;
        logic upper;
    } wtp_dec_type;

    // ****************************************************************
    // Field helpers
    // ****************************************************************
    function automatic logic [3:0] upper_nib(input logic [7:0] b);
        upper_nib = b[7:4];
    endfunction

    function automatic logic [3:0] lower_nib(input logic [7:0] b);
        lower_nib = b[3:0];
    endfunction

    function automatic logic [11:0] thr_join(input logic [7:0] top, input logic [7:0] reg_b);
        thr_join = {top, upper_nib(reg_b)};
    endfunction

    function automatic logic [12:0] hyst_amount(input logic [7:0] reg_b);
        hyst_amount = 13'(lower_nib(reg_b)) << HYST_SHIFT;
    endfunction

endpackage

/* File: rtl/wtp_monitor_regs.sv */
// Window comparator settings, debounce, peak recorders and AXI4-Lite register slave
// Operation
// - High threshold lower nibble sits in hysteresis register bits 7-4, versus code bits 3:0.
// - Low threshold lower nibble sits in debounce register bits 7-4, versus code bits 3:0.
// - Threshold upper bytes are compared against the top eight code bits.
// - One 4-bit hysteresis in bits 3-0 serves both thresholds of a channel.
// - Hysteresis is shifted left three places, a 7-bit amount on low threshold bits.
// - Event flag sets only after n+1 consecutive samples beyond a threshold.
// - Hysteresis register resets to F0: ceiling nibble all ones, hysteresis zero.
// - Ceiling upper byte resets to FF, the largest threshold.
// - Four registers per channel in order hysteresis, ceiling, debounce, floor.
// - Each channel records the largest code seen since its peak lower byte was read.
// - Reading a peak lower byte clears the recorded value to zero, or to a sample of that channel in the same cycle.
// - Peak lower byte at even index from 60, upper byte next, reset zero.
module wtp_monitor_regs #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Conversion results
    input wire logic sample_valid,
    input wire logic [wtp_pkg::CH_W-1:0] sample_chan,
    input wire logic [wtp_pkg::CODE_W-1:0] sample_code,
    // Interrupt
    output logic irq
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic [7:0] hyst_q [wtp_pkg::NUM_CH];
    logic [7:0] ceil_q [wtp_pkg::NUM_CH];
    logic [7:0] deb_q [wtp_pkg::NUM_CH];
    logic [7:0] floor_q [wtp_pkg::NUM_CH];
    logic [11:0] peak_q [wtp_pkg::NUM_CH];
    logic [3:0] shadow_q [wtp_pkg::NUM_CH];
    logic [3:0] cnt_q [wtp_pkg::NUM_CH];
    logic [wtp_pkg::NUM_CH-1:0] over_q;
    logic [wtp_pkg::NUM_CH-1:0] under_q;
    logic [wtp_pkg::NUM_CH-1:0] status_q;
    logic [wtp_pkg::NUM_CH-1:0] mask_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [ADDR_W-1:0] waddr_q;
    logic [7:0] wbyte_q;
    logic wlane_q;
    localparam int LAST_CH = wtp_pkg::NUM_CH - 1;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic wtp_pkg::wtp_dec_type decode(input logic [ADDR_W-1:0] a);
        logic [7:0] idx;
        logic [7:0] moff;
        logic [7:0] poff;
        logic top_ok;
        idx = a[wtp_pkg::IDX_LSB +: wtp_pkg::IDX_W];
        moff = idx - wtp_pkg::IDX_MON_BASE;
        poff = idx - wtp_pkg::IDX_PEAK_BASE;
        top_ok = (a >> (wtp_pkg::IDX_LSB + wtp_pkg::IDX_W)) == '0;
        decode.mon = top_ok && idx >= wtp_pkg::IDX_MON_BASE && moff < wtp_pkg::MON_SPAN;
        decode.pk = top_ok && idx >= wtp_pkg::IDX_PEAK_BASE && poff < wtp_pkg::PEAK_SPAN;
        decode.st = top_ok && idx == wtp_pkg::IDX_EVENT_STATUS;
        decode.mk = top_ok && idx == wtp_pkg::IDX_EVENT_MASK;
        decode.ch = decode.mon ? moff[2 +: wtp_pkg::CH_W] : poff[1 +: wtp_pkg::CH_W];
        decode.fld = moff[1:0];
        decode.upper = poff[0];
    endfunction

    wtp_pkg::wtp_dec_type wr_dec;
    wtp_pkg::wtp_dec_type rd_dec;
    wire wr_fire = aw_hold_q && w_hold_q && !bvalid;
    wire ar_fire = arvalid && arready;
    wire wr_lane = wr_fire && wlane_q;
    assign wr_dec = decode(waddr_q);
    assign rd_dec = decode(araddr);
    assign awready = !aw_hold_q;
    assign wready = !w_hold_q;
    assign arready = !rvalid;

    // ****************************************************************
    // Comparator for the channel of the current sample
    // ****************************************************************
    wire [wtp_pkg::CH_W-1:0] sel = sample_chan;
    // Threshold assembly
    wire [11:0] hi_thr = wtp_pkg::thr_join(ceil_q[sel], hyst_q[sel]);
    wire [11:0] lo_thr = wtp_pkg::thr_join(floor_q[sel], deb_q[sel]);
    // Shared shifted hysteresis
    wire [12:0] hamt = wtp_pkg::hyst_amount(hyst_q[sel]);
    wire [12:0] code_x = {1'b0, sample_code};
    // Full compare: upper byte against top code bits, nibble against low bits
    wire over = over_q[sel] ? (code_x + hamt > {1'b0, hi_thr}) : (sample_code > hi_thr);
    wire under = under_q[sel] ? (code_x < {1'b0, lo_thr} + hamt) : (sample_code < lo_thr);
    wire beyond = over || under;
    wire [3:0] limit = wtp_pkg::lower_nib(deb_q[sel]);
    // Debounce reached
    wire hit = sample_valid && beyond && cnt_q[sel] >= limit;
    wire st_clr = ar_fire && rd_dec.st;
    assign irq = |(status_q & mask_q);

    // ****************************************************************
    // Write channel capture and response
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            waddr_q <= '0;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= wtp_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_hold_q <= 1'b1;
                waddr_q <= awaddr;
            end else if (wr_fire) begin
                aw_hold_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_hold_q <= 1'b1;
                wbyte_q <= wdata[7:0];
                wlane_q <= wstrb[0];
            end else if (wr_fire) begin
                w_hold_q <= 1'b0;
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= (wr_dec.mon || wr_dec.pk || wr_dec.st || wr_dec.mk) ?
                    wtp_pkg::RESP_OKAY : wtp_pkg::RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (rd_dec.mon) begin
            case (rd_dec.fld)
                wtp_pkg::FLD_HYST: rd_byte = hyst_q[rd_dec.ch];
                wtp_pkg::FLD_CEIL: rd_byte = ceil_q[rd_dec.ch];
                wtp_pkg::FLD_DEB: rd_byte = deb_q[rd_dec.ch];
                default: rd_byte = floor_q[rd_dec.ch];
            endcase
        end else if (rd_dec.pk) begin
            rd_byte = rd_dec.upper ? {4'h0, shadow_q[rd_dec.ch]} : peak_q[rd_dec.ch][7:0];
        end else if (rd_dec.st) begin
            rd_byte = status_q;
        end else if (rd_dec.mk) begin
            rd_byte = mask_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= wtp_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, rd_byte};
            rresp <= (rd_dec.mon || rd_dec.pk || rd_dec.st || rd_dec.mk) ?
                wtp_pkg::RESP_OKAY : wtp_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Configuration registers, status and mask
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < wtp_pkg::NUM_CH; i++) begin
                // Power-up defaults
                hyst_q[i] <= wtp_pkg::RST_HYST;
                ceil_q[i] <= wtp_pkg::RST_CEIL;
                deb_q[i] <= wtp_pkg::RST_DEB;
                floor_q[i] <= wtp_pkg::RST_FLOOR;
            end
            mask_q <= wtp_pkg::RST_MASK;
            status_q <= '0;
        end else begin
            // Group layout per channel
            if (wr_lane && wr_dec.mon) begin
                case (wr_dec.fld)
                    wtp_pkg::FLD_HYST: hyst_q[wr_dec.ch] <= wbyte_q;
                    wtp_pkg::FLD_CEIL: ceil_q[wr_dec.ch] <= wbyte_q;
                    wtp_pkg::FLD_DEB: deb_q[wr_dec.ch] <= wbyte_q;
                    default: floor_q[wr_dec.ch] <= wbyte_q;
                endcase
            end
            if (wr_lane && wr_dec.mk) begin
                mask_q <= wbyte_q;
            end
            // Event set wins over read clear
            status_q <= (st_clr ? '0 : status_q) |
                ({{(wtp_pkg::NUM_CH-1){1'b0}}, hit} << sel);
        end
    end

    // ****************************************************************
    // Per-channel debounce, hysteresis state and peak recorders
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < wtp_pkg::NUM_CH; i++) begin
                peak_q[i] <= wtp_pkg::RST_PEAK;
                shadow_q[i] <= 4'h0;
                cnt_q[i] <= 4'h0;
            end
            over_q <= '0;
            under_q <= '0;
        end else begin
            // Consecutive count, restarts on an in-window sample
            if (sample_valid) begin
                over_q[sel] <= over;
                under_q[sel] <= under;
                cnt_q[sel] <= !beyond ? 4'h0 : (cnt_q[sel] >= limit ? cnt_q[sel] :
                    cnt_q[sel] + 4'h1);
            end
            for (int i = 0; i < wtp_pkg::NUM_CH; i++) begin
                // Lower-byte read clears and freezes the upper byte for the pair
                if (ar_fire && rd_dec.pk && !rd_dec.upper && rd_dec.ch == i) begin
                    shadow_q[i] <= peak_q[i][11:8];
                    peak_q[i] <= (sample_valid && sel == i) ? sample_code : wtp_pkg::RST_PEAK;
                end else begin
                    if (ar_fire && rd_dec.pk && rd_dec.upper && rd_dec.ch == i) begin
                        shadow_q[i] <= 4'h0;
                    end
                    // Running maximum
                    if (sample_valid && sel == i && sample_code > peak_q[i]) begin
                        peak_q[i] <= sample_code;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_reset_values;
        @(posedge aclk) disable iff (!aresetn)
        !$past(aresetn) |-> hyst_q[7] == wtp_pkg::RST_HYST && ceil_q[7] == wtp_pkg::RST_CEIL
            && deb_q[7] == wtp_pkg::RST_DEB && floor_q[7] == wtp_pkg::RST_FLOOR;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset value");

    property p_ceiling_default;
        @(posedge aclk) disable iff (!aresetn)
        !$past(aresetn) |-> hi_thr == 12'hFFF && hamt == 13'h0000;
    endproperty
    a_ceiling_default: assert property (p_ceiling_default) else $error("ceiling low");

    property p_cross_high;
        @(posedge aclk) disable iff (!aresetn)
        sample_valid && !over_q[sel] && sample_code > {ceil_q[sel], hyst_q[sel][7:4]}
            |=> over_q[$past(sel)];
    endproperty
    a_cross_high: assert property (p_cross_high) else $error("high crossing missed");

    property p_hyst_hold;
        @(posedge aclk) disable iff (!aresetn)
        sample_valid && over_q[sel] && sample_code <= hi_thr
            && ({1'b0, sample_code} + {6'h00, hyst_q[sel][3:0], 3'h0}) > {1'b0, hi_thr}
            |=> over_q[$past(sel)];
    endproperty
    a_hyst_hold: assert property (p_hyst_hold) else $error("hysteresis not applied");

    property p_debounce;
        @(posedge aclk) disable iff (!aresetn)
        sample_valid && beyond && cnt_q[sel] == deb_q[sel][3:0] |=> status_q[$past(sel)];
    endproperty
    a_debounce: assert property (p_debounce) else $error("event flag not set");

    property p_no_early_event;
        @(posedge aclk) disable iff (!aresetn)
        !status_q[LAST_CH]
            && !(sample_valid && sel == LAST_CH && cnt_q[LAST_CH] >= deb_q[LAST_CH][3:0])
            |=> !status_q[LAST_CH];
    endproperty
    a_no_early_event: assert property (p_no_early_event) else $error("early event");

    property p_peak_track;
        @(posedge aclk) disable iff (!aresetn)
        sample_valid && sample_code > peak_q[sel] |=> peak_q[$past(sel)] == $past(sample_code);
    endproperty
    a_peak_track: assert property (p_peak_track) else $error("peak not tracked");

    property p_peak_clear;
        @(posedge aclk) disable iff (!aresetn)
        ar_fire && rd_dec.pk && !rd_dec.upper && rd_dec.ch == 0 && !(sample_valid && sel == 0)
            |=> peak_q[0] == wtp_pkg::RST_PEAK;
    endproperty
    a_peak_clear: assert property (p_peak_clear) else $error("peak not cleared");

    property p_peak_readonly;
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_dec.pk && !sample_valid && !ar_fire |=> $stable(peak_q[wr_dec.ch]);
    endproperty
    a_peak_readonly: assert property (p_peak_readonly) else $error("peak written");

    property p_write_answer;
        @(posedge aclk) disable iff (!aresetn)
        awvalid && awready && wvalid && wready |-> ##2 bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("late write response");

    property p_cross_low;
        @(posedge aclk) disable iff (!aresetn)
        sample_valid && !under_q[sel] && sample_code < {floor_q[sel], deb_q[sel][7:4]}
            |=> under_q[$past(sel)];
    endproperty
    a_cross_low: assert property (p_cross_low) else $error("low crossing missed");

    property p_low_hyst_hold;
        @(posedge aclk) disable iff (!aresetn)
        sample_valid && under_q[sel] && sample_code >= lo_thr
            && code_x < ({1'b0, lo_thr} + {6'h00, hyst_q[sel][3:0], 3'h0})
            |=> under_q[$past(sel)];
    endproperty
    a_low_hyst_hold: assert property (p_low_hyst_hold) else $error("low hold lost");

    property p_peak_pair;
        @(posedge aclk) disable iff (!aresetn)
        ar_fire && rd_dec.pk && !rd_dec.upper |=> rdata[7:0] == $past(peak_q[rd_dec.ch][7:0])
            && shadow_q[$past(rd_dec.ch)] == $past(peak_q[rd_dec.ch][11:8]);
    endproperty
    a_peak_pair: assert property (p_peak_pair) else $error("peak pair split");

    property p_cfg_write;
        @(posedge aclk) disable iff (!aresetn)
        wr_lane && wr_dec.mon && wr_dec.fld == wtp_pkg::FLD_CEIL
            |=> ceil_q[$past(wr_dec.ch)] == $past(wbyte_q);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("ceiling not written");

    c_event: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
    c_peak_read: cover property (@(posedge aclk) disable iff (!aresetn)
        ar_fire && rd_dec.pk ##1 rvalid && rdata != 32'h0000_0000);
    c_cfg_write: cover property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_dec.mon && wr_dec.fld == wtp_pkg::FLD_DEB);
    c_hyst_hold: cover property (@(posedge aclk) disable iff (!aresetn)
        sample_valid && over_q[sel] && sample_code <= hi_thr && hit);

endmodule

/* File: dv/wtp_sample_src.sv */
// Conversion result source that feeds the monitor slice one sample at a time
module wtp_sample_src (
    // Clock
    input wire logic aclk,
    // Conversion results
    output logic sample_valid,
    output logic [wtp_pkg::CH_W-1:0] sample_chan,
    output logic [wtp_pkg::CODE_W-1:0] sample_code
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sample_valid = 1'b0;
        sample_chan = 3'h0;
        sample_code = 12'h000;
    end

    // ****************************************************************
    // Sample pulse
    // ****************************************************************
    // Idle lines carry the inverse of the last value so stale data never looks valid
    task automatic send(input logic [2:0] ch, input logic [11:0] code);
        @(posedge aclk);
        sample_valid <= 1'b1;
        sample_chan <= ch;
        sample_code <= code;
        @(posedge aclk);
        sample_valid <= 1'b0;
        sample_chan <= ~ch;
        sample_code <= ~code;
    endtask
endmodule

/* File: dv/wtp_monitor_regs_test.sv */
// Self-checking bench for the window threshold and peak register slice
module wtp_monitor_regs_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] A_HY = 12'h0F0, A_CE = 12'h0F4, A_DB = 12'h0F8, A_FL = 12'h0FC;
    localparam logic [11:0] A_PK = 12'h180, A_ST = 12'h1C0, A_MK = 12'h1C4, A_NO = 12'h140;
    localparam logic [1:0] OK = wtp_pkg::RESP_OKAY;
    localparam logic [1:0] ER = wtp_pkg::RESP_SLVERR;
    localparam logic [11:0] HC [0:7] = '{12'h600, 12'h806, 12'h7FE, 12'h7FD,
                                         12'h402, 12'h40A, 12'h40B, 12'h404};
    localparam logic [7:0] HE = 8'h36;

    logic aclk, aresetn;
    logic [11:0] awaddr, araddr, sample_code;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, sample_valid, irq;
    logic [31:0] wdata, rdata, rd_d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rd_r;
    logic [2:0] sample_chan;
    int n_errors, check_count, cycles;

    wtp_monitor_regs #(.ADDR_W(12)) u_wtp_monitor_regs (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .sample_valid(sample_valid), .sample_chan(sample_chan),
        .sample_code(sample_code), .irq(irq)
    );

    wtp_sample_src u_wtp_sample_src (
        .aclk(aclk), .sample_valid(sample_valid),
        .sample_chan(sample_chan), .sample_code(sample_code)
    );

    always #4 aclk = ~aclk;

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end

    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    // Ready is sampled at the falling edge, the transfer lands on the next rising edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er,
        input logic [3:0] s = 4'hF);
        logic ta, tw, tb;
        logic [1:0] r;
        tb = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        chk({32'h00000000, r}, {32'h00000000, er});
    endtask

    task automatic rc(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
        logic ta, tr;
        tr = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid && rready;
            rd_d = rdata;
            rd_r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk({rd_r, rd_d}, {er, 24'h000000, e});
    endtask

    task automatic smp(input logic [2:0] ch, input logic [11:0] c, input logic e);
        u_wtp_sample_src.send(ch, c);
        @(negedge aclk);
        chk({33'h000000000, irq}, {33'h000000000, e});
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h00000000;
        wstrb = 4'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        n_errors = 0;
        check_count = 0;
        cycles = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rc(A_HY, 8'hF0, OK);
        rc(A_CE, 8'hFF, OK);
        rc(A_DB, 8'h00, OK);
        rc(A_FL, 8'h00, OK);
        rc(12'h0EC, 8'h00, OK);
        rc(A_PK, 8'h00, OK);
        rc(A_PK + 12'h004, 8'h00, OK);
        rc(A_MK, 8'h00, OK);
        rc(A_ST, 8'h00, OK);
        wr(A_NO, 8'hAA, ER);
        rc(A_NO, 8'h00, ER);
        // Peak recorders on two channels
        smp(3'h0, 12'h123, 1'b0);
        smp(3'h0, 12'hABC, 1'b0);
        smp(3'h0, 12'h456, 1'b0);
        smp(3'h1, 12'hFFF, 1'b0);
        wr(A_PK, 8'h55, OK);
        rc(A_PK, 8'hBC, OK);
        rc(A_PK + 12'h004, 8'h0A, OK);
        rc(A_PK, 8'h00, OK);
        rc(A_PK + 12'h004, 8'h00, OK);
        rc(A_PK + 12'h008, 8'hFF, OK);
        rc(A_PK + 12'h00C, 8'h0F, OK);
        smp(3'h0, 12'h010, 1'b0);
        rc(A_PK, 8'h10, OK);
        // Window on channel 7: ceiling 805, floor 403, count 2
        wr(A_HY, 8'h50, OK);
        wr(A_CE, 8'h80, OK);
        wr(A_DB, 8'h32, OK);
        wr(A_FL, 8'h40, OK);
        rc(A_HY, 8'h50, OK);
        rc(A_CE, 8'h80, OK);
        rc(A_DB, 8'h32, OK);
        rc(A_FL, 8'h40, OK);
        // Byte lane zero off: the write is dropped
        wr(A_FL, 8'h77, OK, 4'hE);
        rc(A_FL, 8'h40, OK);
        wr(A_MK, 8'h80, OK);
        smp(3'h7, 12'h805, 1'b0);
        for (int k = 0; k < 3; k++) begin
            smp(3'h7, 12'h806, k == 2);
        end
        rc(A_ST, 8'h80, OK);
        chk({33'h000000000, irq}, 34'h000000000);
        smp(3'h7, 12'h403, 1'b0);
        for (int k = 0; k < 3; k++) begin
            smp(3'h7, 12'h402, k == 2);
        end
        rc(A_ST, 8'h80, OK);
        // Hysteresis of one step, count zero
        wr(A_HY, 8'h51, OK);
        wr(A_DB, 8'h30, OK);
        for (int i = 0; i < 8; i++) begin
            smp(3'h7, HC[i], HE[i]);
            if (HE[i]) rc(A_ST, 8'h80, OK);
        end
        // Masked event still sets status
        wr(A_MK, 8'h00, OK);
        smp(3'h7, 12'h900, 1'b0);
        rc(A_ST, 8'h80, OK);
        // Reset in mid-run restores the defaults
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rc(A_HY, 8'hF0, OK);
        rc(A_CE, 8'hFF, OK);
        rc(A_ST, 8'h00, OK);
        results();
    end
endmodule
